// File: logic/dtod_decoder.sv
// Purpose: decode the data transfer group from an instruction byte stream
// Assumes: byte_valid marks one byte per clock, bytes in fetch order
// Notes: every output is registered; done is a one-cycle pulse
`timescale 1ns/10ps
module dtod_decoder (
    input wire logic clock, // 20 MHz decoder clock
    input wire logic rst_b, // asynchronous reset, active low
    input wire logic byte_valid, // instruction byte present
    input wire logic [7:0] byte_data, // instruction byte
    output logic done, // pulse: operation fully decoded
    output dtod_pkg::dtod_op_t op, // decoded operation class
    output logic [1:0] mod_field, // addressing form
    output logic [2:0] reg_field, // selected general register
    output logic [1:0] seg_field, // selected segment register
    output logic [2:0] rm_field, // operand locator
    output logic word_op, // word operand when high
    output logic [15:0] disp, // displacement, sign extended
    output logic [15:0] imm, // immediate data
    output logic writes_data_seg, // load also writes data segment
    output logic writes_extra_seg, // load also writes extra segment
    output logic field_error, // pulse: reserved zero bit was set
    output logic bad_opcode // pulse: first byte not in this group
);
    import dtod_pkg::*;

    // ==========================================================
    // state
    // every flop lives in this struct, so outputs read it directly
    typedef struct packed {
        dtod_state_t st; // byte position within instruction
        dtod_op_t op; // class being decoded
        logic [1:0] mod_f; // addressing form
        logic [2:0] reg_f; // register select
        logic [1:0] seg_f; // segment select
        logic [2:0] rm_f; // operand locator
        logic word; // operand size
        logic wide_disp; // two displacement bytes
        logic has_imm; // data bytes follow displacement
        logic [15:0] disp; // displacement
        logic [15:0] imm; // immediate
        logic ds_w; // data segment written
        logic es_w; // extra segment written
        logic done; // completion pulse
        logic ferr; // reserved bit pulse
        logic bad; // unknown opcode pulse
    } dtod_s_t;

    dtod_s_t s_reg; // registered state
    dtod_s_t s_next; // next state

    // ==========================================================
    // next state
    always_comb begin
        s_next = s_reg;
        // pulses last one cycle only
        s_next.done = 1'b0;
        s_next.ferr = 1'b0;
        s_next.bad = 1'b0;
        // gaps simply wait; no byte is ever refused or stalled
        if (byte_valid) begin
            case (s_reg.st)
                ST_OPCODE: begin
                    // fresh instruction: clear per-instruction fields
                    s_next.mod_f = MOD_NO_DISP;
                    s_next.reg_f = 3'h0;
                    s_next.seg_f = 2'h0;
                    s_next.rm_f = 3'h0;
                    s_next.disp = 16'h0000;
                    s_next.imm = 16'h0000;
                    s_next.ds_w = 1'b0;
                    s_next.es_w = 1'b0;
                    s_next.has_imm = 1'b0;
                    s_next.word = 1'b1;
                    s_next.st = ST_FIELDS;
                    if (byte_data == OPB_SEG_FROM_RM) begin
                        s_next.op = OPC_COPY_TRANSFER_TO_SEG;
                    end else if (byte_data == OPB_SEG_TO_RM) begin
                        s_next.op = OPC_COPY_TRANSFER_FROM_SEG;
                    end else if (byte_data == OPB_EFF_ADDR) begin
                        s_next.op = OPC_LOAD_EFFECTIVE_ADDRESS;
                    end else if (byte_data == OPB_PTR_DATA_SEG) begin
                        s_next.op = OPC_LOAD_POINTER_DATA_SEGMENT;
                        s_next.ds_w = 1'b1;
                    end else if (byte_data == OPB_PTR_EXTRA_SEG) begin
                        s_next.op = OPC_LOAD_POINTER_EXTRA_SEGMENT;
                        s_next.es_w = 1'b1;
                    end else if (byte_data[7:1] == OPB_COPY_IMM_TOP) begin
                        // size bit picks byte or word operand
                        s_next.op = OPC_COPY_TRANSFER_IMMEDIATE;
                        s_next.word = byte_data[SIZE_BIT];
                        s_next.has_imm = 1'b1;
                    end else begin
                        // single byte forms finish right here
                        s_next.st = ST_OPCODE;
                        s_next.done = 1'b1;
                        if (byte_data == OPB_TABLE_TRANSLATE) begin
                            s_next.op = OPC_TABLE_TRANSLATE;
                            s_next.word = 1'b0;
                        end else if (byte_data == OPB_FLAGS_TO_HIGH) begin
                            s_next.op = OPC_FLAGS_TO_HIGH_ACCUMULATOR;
                            s_next.word = 1'b0;
                        end else if (byte_data == OPB_HIGH_TO_FLAGS) begin
                            s_next.op = OPC_HIGH_ACCUMULATOR_TO_FLAGS;
                            s_next.word = 1'b0;
                        end else if (byte_data == OPB_FLAG_SAVE) begin
                            s_next.op = OPC_FLAG_WORD_SAVE;
                        end else if (byte_data == OPB_FLAG_RESTORE) begin
                            s_next.op = OPC_FLAG_WORD_RESTORE;
                        end else begin
                            // outside this group: flag it, stay aligned
                            s_next.op = OPC_NONE;
                            s_next.done = 1'b0;
                            s_next.bad = 1'b1;
                        end
                    end
                end
                ST_FIELDS: begin
                    // addressing form, select and locator fields
                    s_next.mod_f = byte_data[MOD_HI:MOD_LO];
                    s_next.reg_f = byte_data[REG_HI:REG_LO];
                    s_next.rm_f = byte_data[RM_HI:RM_LO];
                    if (s_reg.op == OPC_COPY_TRANSFER_TO_SEG ||
                        s_reg.op == OPC_COPY_TRANSFER_FROM_SEG) begin
                        // zero bit ahead of the segment selector
                        s_next.seg_f = byte_data[SEG_HI:SEG_LO];
                        s_next.ferr = byte_data[SEG_ZERO_BIT];
                    end
                    // a reserved bit error still lets the decode complete
                    if (s_reg.op == OPC_COPY_TRANSFER_IMMEDIATE) begin
                        // immediate form keeps zeros in the select field
                        s_next.ferr = (byte_data[REG_HI:REG_LO] != 3'h0);
                    end
                    // displacement length follows the addressing form
                    s_next.wide_disp = 1'b0;
                    if (byte_data[MOD_HI:MOD_LO] == MOD_DISP8) begin
                        s_next.st = ST_DISP_LO;
                    end else if (byte_data[MOD_HI:MOD_LO] == MOD_DISP16 ||
                        (byte_data[MOD_HI:MOD_LO] == MOD_NO_DISP &&
                        byte_data[RM_HI:RM_LO] == RM_DIRECT)) begin
                        s_next.st = ST_DISP_LO;
                        s_next.wide_disp = 1'b1;
                    end else if (s_reg.has_imm) begin
                        s_next.st = ST_IMM_LO;
                    end else begin
                        s_next.st = ST_OPCODE;
                        s_next.done = 1'b1;
                    end
                end
                ST_DISP_LO: begin
                    // short displacement is sign extended
                    s_next.disp = {{8{byte_data[7]}}, byte_data};
                    if (s_reg.wide_disp) begin
                        s_next.st = ST_DISP_HI;
                    end else if (s_reg.has_imm) begin
                        s_next.st = ST_IMM_LO;
                    end else begin
                        s_next.st = ST_OPCODE;
                        s_next.done = 1'b1;
                    end
                end
                ST_DISP_HI: begin
                    // high byte replaces the sign extension of the low one
                    s_next.disp = {byte_data, s_reg.disp[7:0]};
                    if (s_reg.has_imm) begin
                        s_next.st = ST_IMM_LO;
                    end else begin
                        s_next.st = ST_OPCODE;
                        s_next.done = 1'b1;
                    end
                end
                ST_IMM_LO: begin
                    // first data byte; a byte operand ends here
                    s_next.imm = {8'h00, byte_data};
                    if (s_reg.word) begin
                        s_next.st = ST_IMM_HI;
                    end else begin
                        s_next.st = ST_OPCODE;
                        s_next.done = 1'b1;
                    end
                end
                ST_IMM_HI: begin
                    // second data byte of a word immediate
                    s_next.imm = {byte_data, s_reg.imm[7:0]};
                    s_next.st = ST_OPCODE;
                    s_next.done = 1'b1;
                end
                default: begin
                    // unreachable encodings fall back to realignment
                    s_next.st = ST_OPCODE;
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    // reset clears every field: op reads none, word_op reads byte
    // a stray byte during reset is lost, the stream restarts at an opcode
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    // no gates after the flops, so downstream sees clean timing
    // fields change while bytes arrive; read them only with done
    assign done = s_reg.done;
    assign op = s_reg.op;
    assign mod_field = s_reg.mod_f;
    assign reg_field = s_reg.reg_f;
    assign seg_field = s_reg.seg_f;
    assign rm_field = s_reg.rm_f;
    assign word_op = s_reg.word;
    assign disp = s_reg.disp;
    assign imm = s_reg.imm;
    assign writes_data_seg = s_reg.ds_w;
    assign writes_extra_seg = s_reg.es_w;
    assign field_error = s_reg.ferr;
    assign bad_opcode = s_reg.bad;

endmodule

// File: pkg/dtod_pkg.sv
// Purpose: constants and types for the data transfer opcode decoder
// Assumes: one instruction byte per strobe, lowest address first
// Notes: the byte stream is synchronous to the decoder clock
// Notes on behaviour
// - 8E opcode copies operand into segment register
// - 8C opcode copies segment register into operand
// - D7 single byte is table translate
// - 8D plus field byte loads effective address
// - C5 pointer load writes register and data segment
// - C4 pointer load writes register and extra segment
// - 9F 9E 9C 9D are four flag transfers
package dtod_pkg;

    // ==========================================================
    // first byte encodings
    localparam logic [7:0] OPB_SEG_FROM_RM = 8'h8E;
    localparam logic [7:0] OPB_SEG_TO_RM = 8'h8C;
    localparam logic [7:0] OPB_TABLE_TRANSLATE = 8'hD7;
    localparam logic [7:0] OPB_EFF_ADDR = 8'h8D;
    localparam logic [7:0] OPB_PTR_DATA_SEG = 8'hC5;
    localparam logic [7:0] OPB_PTR_EXTRA_SEG = 8'hC4;
    localparam logic [7:0] OPB_FLAGS_TO_HIGH = 8'h9F;
    localparam logic [7:0] OPB_HIGH_TO_FLAGS = 8'h9E;
    localparam logic [7:0] OPB_FLAG_SAVE = 8'h9C;
    localparam logic [7:0] OPB_FLAG_RESTORE = 8'h9D;
    // immediate copy into operand, lowest bit is the size bit
    localparam logic [6:0] OPB_COPY_IMM_TOP = 7'h63;

    // ==========================================================
    // second byte field positions
    localparam int MOD_HI = 7;
    localparam int MOD_LO = 6;
    localparam int REG_HI = 5;
    localparam int REG_LO = 3;
    localparam int SEG_ZERO_BIT = 5;
    localparam int SEG_HI = 4;
    localparam int SEG_LO = 3;
    localparam int RM_HI = 2;
    localparam int RM_LO = 0;
    localparam int SIZE_BIT = 0;

    // ==========================================================
    // addressing form values
    localparam logic [1:0] MOD_NO_DISP = 2'h0;
    localparam logic [1:0] MOD_DISP8 = 2'h1;
    localparam logic [1:0] MOD_DISP16 = 2'h2;
    localparam logic [1:0] MOD_REGISTER = 2'h3;
    localparam logic [2:0] RM_DIRECT = 3'h6;

    // ==========================================================
    // decoded operation classes
    typedef enum logic [3:0] {
        OPC_NONE,
        OPC_COPY_TRANSFER_TO_SEG,
        OPC_COPY_TRANSFER_FROM_SEG,
        OPC_TABLE_TRANSLATE,
        OPC_LOAD_EFFECTIVE_ADDRESS,
        OPC_LOAD_POINTER_DATA_SEGMENT,
        OPC_LOAD_POINTER_EXTRA_SEGMENT,
        OPC_FLAGS_TO_HIGH_ACCUMULATOR,
        OPC_HIGH_ACCUMULATOR_TO_FLAGS,
        OPC_FLAG_WORD_SAVE,
        OPC_FLAG_WORD_RESTORE,
        OPC_COPY_TRANSFER_IMMEDIATE
    } dtod_op_t;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_FIELDS,
        ST_DISP_LO,
        ST_DISP_HI,
        ST_IMM_LO,
        ST_IMM_HI
    } dtod_state_t;

endpackage

// File: bench/dtod_decoder_asserts.sv
// Purpose: port-level properties of the opcode decoder
// Assumes: sees only the decoder ports; pulses last one cycle
// Notes: the last byte of any op is taken the edge before done
`timescale 1ns/10ps
module dtod_decoder_chk (
    input wire logic clock, // decoder clock
    input wire logic rst_b, // async reset, active low
    input wire logic byte_valid, // byte present
    input wire logic [7:0] byte_data, // instruction byte
    input wire logic done, // decode finished pulse
    input wire dtod_pkg::dtod_op_t op, // decoded class
    input wire logic word_op, // word operand
    input wire logic [15:0] imm, // immediate data
    input wire logic writes_data_seg, // data segment target
    input wire logic writes_extra_seg // extra segment target
);
    import dtod_pkg::*;

    // ==========================================================
    // one domain, so one clocking and one disable for all
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    done_cause_a: assert property (done |-> $past(byte_valid))
        else $error("done without a byte taken");
    lookup_byte_a: assert property (done && op == OPC_TABLE_TRANSLATE
        |-> $past(byte_data) == 8'hD7 && !word_op) else $error("lookup");
    flag_high_a: assert property (done
        && op == OPC_FLAGS_TO_HIGH_ACCUMULATOR
        |-> $past(byte_data) == 8'h9F && !word_op) else $error("flag byte");
    flag_save_a: assert property (done && op == OPC_FLAG_WORD_SAVE
        |-> $past(byte_data) == 8'h9C && word_op) else $error("flag save");
    data_ptr_a: assert property (done
        && op == OPC_LOAD_POINTER_DATA_SEGMENT
        |-> writes_data_seg && !writes_extra_seg) else $error("data ptr");
    extra_ptr_a: assert property (done
        && op == OPC_LOAD_POINTER_EXTRA_SEGMENT
        |-> writes_extra_seg && !writes_data_seg) else $error("extra ptr");
    seg_word_a: assert property (done
        && (op == OPC_COPY_TRANSFER_TO_SEG
        || op == OPC_COPY_TRANSFER_FROM_SEG) |-> word_op) else $error("seg");
    imm_byte_a: assert property (done
        && op == OPC_COPY_TRANSFER_IMMEDIATE
        && !word_op |-> imm[15:8] == 8'h00) else $error("byte immediate");
endmodule

bind dtod_decoder dtod_decoder_chk u_chk (.clock, .rst_b, .byte_valid,
    .byte_data, .done, .op, .word_op, .imm, .writes_data_seg,
    .writes_extra_seg);

// File: bench/dtod_byte_source.sv
// Purpose: instruction memory model feeding fetched bytes
// Assumes: bench pushes bytes into fifo between clock edges
// Notes: idle data toggles so a stale byte never looks valid
`timescale 1ns/10ps
module dtod_byte_source (
    input wire logic clock, // decoder clock
    output logic byte_valid, // byte present
    output logic [7:0] byte_data // instruction byte
);
    logic [7:0] fifo[$]; // bytes still to fetch
    logic slow; // insert an idle cycle before each byte
    logic gap; // idle cycle just spent
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
        slow = 1'b0;
        gap = 1'b0;
    end
    // one byte per edge, or every other edge when slow
    always @(posedge clock) begin
        if (fifo.size() != 0 && (!slow || gap)) begin
            byte_valid <= 1'b1;
            byte_data <= fifo.pop_front();
            gap <= 1'b0;
        end else begin
            byte_valid <= 1'b0;
            byte_data <= ~byte_data;
            gap <= 1'b1;
        end
    end
endmodule

// File: bench/testbench.sv
// Purpose: directed scenarios for the opcode decoder
// Assumes: bytes come from the memory model, results read at done
// Notes: outputs sampled on the falling edge, clear of updates
`timescale 1ns/10ps
module testbench;
    import dtod_pkg::*;
    logic clock, rst_b, byte_valid, done, word_op, field_error, bad_opcode;
    logic writes_data_seg, writes_extra_seg, saw_err, saw_bad;
    logic [7:0] byte_data;
    logic [1:0] mod_field, seg_field;
    logic [2:0] reg_field, rm_field;
    logic [15:0] disp, imm;
    dtod_op_t op;
    int mismatches, n_checks;
    always #25 clock = ~clock;
    dtod_byte_source src (.clock, .byte_valid, .byte_data);
    dtod_decoder DUT (.clock, .rst_b, .byte_valid, .byte_data, .done, .op,
        .mod_field, .reg_field, .seg_field, .rm_field, .word_op, .disp,
        .imm, .writes_data_seg, .writes_extra_seg, .field_error,
        .bad_opcode);
    // ==========================================================
    // shared helpers
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // queue n bytes (first in top byte), wait for done or bad_opcode
    task automatic feed(input int n, input logic [47:0] bs);
        int k;
        saw_err = 1'b0;
        saw_bad = 1'b0;
        for (k = 0; k < n; k++) src.fifo.push_back(bs[47-8*k -: 8]);
        for (k = 0; k < 40; k++) begin
            @(negedge clock);
            saw_err |= field_error;
            saw_bad |= bad_opcode;
            if (done === 1'b1 || bad_opcode === 1'b1) break;
        end
        if (k == 40) begin
            mismatches++;
            test_done();
        end
    endtask
    // f packs data seg, extra seg, word, mod, rm
    task automatic expect_dec(input dtod_op_t o, input logic [7:0] f,
                              input logic [15:0] d, i);
        check(16'(op), 16'(o));
        check({8'h00, writes_data_seg, writes_extra_seg, word_op,
               mod_field, rm_field}, {8'h00, f});
        check(disp, d);
        check(imm, i);
    endtask
    // ==========================================================
    // scenarios
    task automatic s_seg_moves();
        feed(2, 48'h8ED800000000);
        expect_dec(OPC_COPY_TRANSFER_TO_SEG, 8'h38, 0, 0);
        check(16'(seg_field), 16'h0003);
        feed(4, 48'h8C1E34120000);
        expect_dec(OPC_COPY_TRANSFER_FROM_SEG, 8'h26, 16'h1234, 0);
        check(16'(seg_field), 16'h0003);
        feed(2, 48'h8EE000000000);
        check(16'(saw_err), 16'h0001);
    endtask
    task automatic s_lookup_flags();
        logic [7:0] ob[5] = '{8'hD7, 8'h9F, 8'h9E, 8'h9C, 8'h9D};
        dtod_op_t oc[5] = '{OPC_TABLE_TRANSLATE,
            OPC_FLAGS_TO_HIGH_ACCUMULATOR, OPC_HIGH_ACCUMULATOR_TO_FLAGS,
            OPC_FLAG_WORD_SAVE, OPC_FLAG_WORD_RESTORE};
        for (int k = 0; k < 5; k++) begin
            feed(1, {ob[k], 40'h0});
            expect_dec(oc[k], (k > 2) ? 8'h20 : 8'h00, 0, 0);
        end
        // back to back: next opcode in the very next cycle
        feed(2, 48'hD79F00000000);
        check(16'(op), 16'(OPC_TABLE_TRANSLATE));
        feed(0, 0);
        check(16'(op), 16'(OPC_FLAGS_TO_HIGH_ACCUMULATOR));
    endtask
    task automatic s_eff_addr();
        feed(3, 48'h8D46F0000000);
        expect_dec(OPC_LOAD_EFFECTIVE_ADDRESS, 8'h2E, 16'hFFF0, 0);
        feed(4, 48'h8D9F00800000);
        expect_dec(OPC_LOAD_EFFECTIVE_ADDRESS, 8'h37, 16'h8000, 0);
        check(16'(reg_field), 16'h0003);
    endtask
    task automatic s_ptr_loads();
        feed(3, 48'hC5567F000000);
        expect_dec(OPC_LOAD_POINTER_DATA_SEGMENT, 8'hAE, 16'h007F, 0);
        check(16'(reg_field), 16'h0002);
        feed(4, 48'hC40E00200000);
        expect_dec(OPC_LOAD_POINTER_EXTRA_SEGMENT, 8'h66, 16'h2000,
                   16'h0000);
        check(16'(reg_field), 16'h0001);
    endtask
    task automatic s_size_bit();
        feed(3, 48'hC6C0AB000000);
        expect_dec(OPC_COPY_TRANSFER_IMMEDIATE, 8'h18, 0, 16'h00AB);
        src.slow = 1'b1;
        feed(6, 48'hC70634127856);
        expect_dec(OPC_COPY_TRANSFER_IMMEDIATE, 8'h26, 16'h1234,
                   16'h5678);
        src.slow = 1'b0;
    endtask
    task automatic s_bad_then_lookup();
        feed(2, 48'h8FD700000000);
        check({saw_bad, 15'(op)}, {1'b1, 15'(OPC_NONE)});
        feed(0, 0);
        check(16'(op), 16'(OPC_TABLE_TRANSLATE));
    endtask
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        mismatches = 0;
        n_checks = 0;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        s_seg_moves();
        s_lookup_flags();
        s_eff_addr();
        s_ptr_loads();
        s_size_bit();
        s_bad_then_lookup();
        test_done();
    end
endmodule
